/* dv/erf_filter_cfg_properties.sv */
`timescale 1ns/1ps
module erf_filter_cfg_properties
  import erf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic receiveOn,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic frameDone,
  input wire logic csumEqual,
  input wire logic daStation,
  input wire logic daUnicast,
  input wire logic daBroadcast,
  input wire logic hashHit,
  input wire logic wakeFrame,
  input wire logic matchValid,
  input wire logic patternMatchOk,
  input wire logic hashPass,
  input wire logic wakePass
);
  logic [31:0] cfg_q;
  logic [15:0] cls;
  logic expOk;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow config; writes dropped while receiving
  always_ff @(posedge clk)
    if (!rst_n) cfg_q <= ERF_ZERO;
    else if (pready && pwrite && paddr == ERF_RXFC_OFS && !receiveOn)
      cfg_q <= pwdata & ERF_RXFC_MASK;
  // Class per mode; codes 10-15 never match
  assign cls = {6'h0, wakeFrame, hashHit, {2{daBroadcast}}, {2{daUnicast}}, {2{daStation}}, 2'h2};
  assign expOk = cls[cfg_q[11:8]] & (cfg_q[12] ^ csumEqual);
  a_valid_pulse: assert property (frameDone |=> matchValid) else $error("no valid");
  a_result_held: assert property (!frameDone |=> !matchValid && $stable(patternMatchOk))
    else $error("spurious result");
  a_match_calc: assert property (frameDone |=> patternMatchOk == $past(expOk))
    else $error("bad match");
  a_mode_off: assert property (frameDone && cfg_q[11:8] == ERF_PM_OFF |=> !patternMatchOk)
    else $error("match while off");
  a_hash_gate: assert property (frameDone |=> hashPass == ($past(hashHit) | !cfg_q[15]))
    else $error("bad hash pass");
  a_wake_gate: assert property (frameDone |=> wakePass == ($past(wakeFrame) | !cfg_q[14]))
    else $error("bad wake pass");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready) else $error("bad ready");
  a_read_cfg: assert property (pready && !pwrite && paddr == ERF_RXFC_OFS |-> prdata == cfg_q)
    else $error("bad readback");
  cover property (frameDone ##1 patternMatchOk);
  cover property (pready && pwrite && receiveOn);
  cover property (frameDone && cfg_q[11:8] == ERF_PM_WAKE);
endmodule // erf_filter_cfg_properties
bind erf_filter_cfg erf_filter_cfg_properties i_erf_filter_cfg_properties (
  .clk(clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .receiveOn(receiveOn),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .frameDone(frameDone),
  .csumEqual(csumEqual),
  .daStation(daStation),
  .daUnicast(daUnicast),
  .daBroadcast(daBroadcast),
  .hashHit(hashHit),
  .wakeFrame(wakeFrame),
  .matchValid(matchValid),
  .patternMatchOk(patternMatchOk),
  .hashPass(hashPass),
  .wakePass(wakePass)
);

/* dv/erf_filter_cfg_test.sv */
`timescale 1ns/1ps
module erf_filter_cfg_test
  import erf_pkg::*;
;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, frameDone = 0, err;
  logic csumEqual = 0, daStation = 0, daUnicast = 0, daBroadcast = 0, hashHit = 0, wakeFrame = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, receiveOn, matchValid, patternMatchOk, hashPass, wakePass;
  logic [7:0] lowFilterEn;
  int miscompares = 0, checksDone = 0, cycles = 0;
  erf_filter_cfg i_erf_filter_cfg (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .frameDone(frameDone),
    .csumEqual(csumEqual),
    .daStation(daStation),
    .daUnicast(daUnicast),
    .daBroadcast(daBroadcast),
    .hashHit(hashHit),
    .wakeFrame(wakeFrame),
    .receiveOn(receiveOn),
    .matchValid(matchValid),
    .patternMatchOk(patternMatchOk),
    .hashPass(hashPass),
    .wakePass(wakePass),
    .lowFilterEn(lowFilterEn)
  );
  always #2.5 clk = ~clk;
  // Hang guard; full run needs about 1150 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    if (miscompares == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // One APB transfer, then one idle edge so strobes never toggle twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic frame(input logic [5:0] v, input logic e, input logic en);
    {csumEqual, daStation, daUnicast, daBroadcast, hashHit, wakeFrame} <= v;
    frameDone <= 1;
    @(posedge clk) frameDone <= 0;
    @(posedge clk) cmp("valid", 1, matchValid);
    cmp("match", e, patternMatchOk);
    cmp("hash pass", v[1] | !en, hashPass);
    cmp("wake pass", v[0] | !en, wakePass);
  endtask
  task automatic t_regs();
    apb(0, ERF_RXFC_OFS, 0);
    cmp("cfg reset", ERF_RXFC_RST, rd);
    apb(1, ERF_RXFC_OFS, '1);
    apb(0, ERF_RXFC_OFS, 0);
    cmp("cfg mask", ERF_RXFC_MASK, rd);
    cmp("low en", 8'hff, lowFilterEn);
    apb(0, 12'h0fc, 0);
    cmp("slverr", 1, err);
  endtask
  // Writes while receiving must not land
  task automatic t_lock();
    apb(1, ERF_CTRL_OFS, 1);
    cmp("rx on", 1, receiveOn);
    apb(1, ERF_RXFC_OFS, 32'h0000_0100);
    apb(0, ERF_RXFC_OFS, 0);
    cmp("locked", ERF_RXFC_MASK, rd);
    apb(1, ERF_CTRL_OFS, 0);
  endtask
  // Every mode, both inversions, enables on and off, each input knocked out once
  task automatic t_modes();
    logic c;
    for (int m = 0; m < 16; m++)
      for (int k = 0; k < 4; k++) begin
        apb(1, ERF_RXFC_OFS, {16'h0, k[1], k[1], 1'b0, k[0], m[3:0], 8'h0});
        for (int j = 0; j < 7; j++) begin
          logic [5:0] v = 6'h3f ^ (6'h1 << j);
          case (m)
            1: c = 1;
            2, 3: c = v[4];
            4, 5: c = v[3];
            6, 7: c = v[2];
            8: c = v[1];
            9: c = v[0];
            default: c = 0;
          endcase
          frame(v, c & (k[0] ^ v[5]), k[1]);
        end
      end
  endtask
  // Status and control readback, then a mid-run reset clears everything
  task automatic t_reset();
    apb(1, ERF_RXFC_OFS, 32'h0000_c100);
    frame(6'h3f, 1, 1);
    apb(1, ERF_CTRL_OFS, 1);
    apb(0, ERF_STAT_OFS, 0);
    cmp("status", 32'h0000_000d, rd);
    apb(0, ERF_CTRL_OFS, 0);
    cmp("ctrl", 32'h0000_0001, rd);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    cmp("rx off", 0, receiveOn);
    cmp("match clr", 0, patternMatchOk);
    cmp("hash clr", 0, hashPass);
    cmp("wake clr", 0, wakePass);
    cmp("low clr", 0, lowFilterEn);
    apb(0, ERF_RXFC_OFS, 0);
    cmp("cfg clr", ERF_RXFC_RST, rd);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_regs();
    t_lock();
    t_modes();
    t_reset();
    close_out();
  end
endmodule // erf_filter_cfg_test

/* verilog/erf_filter_cfg.sv */
// Behaviour
// - Hash filtering only while hash_filter_on set
// - Wake-frame filtering only while wake_frame_filter_on set
// - Checksum condition is invert XOR equal
// - Mode zero: match always unsuccessful
// - Mode one: checksum condition alone
// - Modes two/three: plus station address
// - Modes four/five: plus unicast address
// - Modes six/seven: plus broadcast address
// - Mode eight: plus hash hit, ignoring enable
// - Mode nine: plus wake frame, ignoring enable
// - Bits 31-16 and 13 read zero
// - Configuration affects receive path only
`timescale 1ns/1ps
module erf_filter_cfg
  import erf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frameDone,
  input wire logic csumEqual,
  input wire logic daStation,
  input wire logic daUnicast,
  input wire logic daBroadcast,
  input wire logic hashHit,
  input wire logic wakeFrame,
  output logic receiveOn,
  output logic matchValid,
  output logic patternMatchOk,
  output logic hashPass,
  output logic wakePass,
  output logic [ERF_LOW_W-1:0] lowFilterEn
);

  // Configuration register and receive enable
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic rxOn_q;
  logic rxOn_d;

  // Bus answer registers
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic ready_q;
  logic ready_d;
  logic err_q;
  logic err_d;

  // Per-frame result registers
  logic valid_q;
  logic valid_d;
  logic match_q;
  logic match_d;
  logic hash_q;
  logic hash_d;
  logic wake_q;
  logic wake_d;

  // Bus phase and address decode
  logic setupPhase;
  logic accessEnd;
  logic selCfg;
  logic selStat;
  logic selCtrl;
  logic hit;
  logic cfgWrite;
  logic ctrlWrite;

  // Words offered to the read multiplexer
  logic [31:0] cfgWord;
  logic [31:0] statWord;
  logic [31:0] ctrlWord;
  logic [31:0] readWord;

  // Configuration fields
  logic [ERF_MODE_W-1:0] mode;
  logic invertOn;
  logic hashOn;
  logic wakeOn;

  // Pattern match terms
  logic csumOk; // Checksum condition after inversion
  logic classOk; // Frame class wanted by the mode
  logic modeOk;
  logic hashGate;
  logic wakeGate;

  // Answer is registered at setup, so the access phase never waits;
  // the ready term keeps a held setup from being answered twice
  assign setupPhase = psel && !penable && !ready_q;
  // Completing edge: pready seen high together with psel and penable
  assign accessEnd = psel && penable && ready_q;

  // Address decode; whole words only, no byte strobes
  assign selCfg = (paddr == ERF_RXFC_OFS);
  assign selStat = (paddr == ERF_STAT_OFS);
  assign selCtrl = (paddr == ERF_CTRL_OFS);
  assign hit = selCfg || selStat || selCtrl;

  // Refused writes still get pready; software must read back
  // to learn whether the value landed
  // config frozen while receiving
  assign cfgWrite = accessEnd && pwrite && selCfg && !rxOn_q;
  // Receive enable itself is always writable
  assign ctrlWrite = accessEnd && pwrite && selCtrl;

  // Field views of the configuration; bits 7:0 are only passed on
  assign mode = cfg_q[ERF_MODE_LSB +: ERF_MODE_W];
  assign invertOn = cfg_q[ERF_INV_BIT];
  assign hashOn = cfg_q[ERF_HASH_BIT];
  assign wakeOn = cfg_q[ERF_WAKE_BIT];

  assign cfgWord = cfg_q & ERF_RXFC_MASK;

  // Status word: results of the last frame
  // Valid reads high only if a frame ends in the cycle before setup
  always_comb begin
    statWord = ERF_ZERO;
    statWord[ERF_ST_MATCH] = match_q;
    statWord[ERF_ST_VALID] = valid_q;
    statWord[ERF_ST_HASH] = hash_q;
    statWord[ERF_ST_WAKE] = wake_q;
  end

  // Control word: only the receive enable is kept
  // Other control bits are not stored and read zero
  always_comb begin
    ctrlWord = ERF_ZERO;
    ctrlWord[ERF_RXON_BIT] = rxOn_q;
  end

  // Read multiplexer; unmapped addresses read zero
  // Priority order is moot, the selects are exclusive
  always_comb begin
    readWord = ERF_ZERO;
    if (selCfg) begin
      readWord = cfgWord;
    end else if (selStat) begin
      readWord = statWord;
    end else if (selCtrl) begin
      readWord = ctrlWord;
    end
  end

  // Bus answer: status is snapshotted at setup, so a frame ending in
  // the access cycle shows up on the next read only
  always_comb begin
    rdata_d = ERF_ZERO;
    ready_d = 1'h0;
    err_d = 1'h0;
    if (setupPhase) begin
      ready_d = 1'h1;
      err_d = !hit; // Unmapped address: error, write dropped
      if (!pwrite) begin
        rdata_d = readWord;
      end
    end
  end

  // Configuration next state; writes land on the completing edge
  always_comb begin
    cfg_d = cfg_q;
    rxOn_d = rxOn_q;
    if (cfgWrite) begin
      cfg_d = pwdata & ERF_RXFC_MASK;
    end
    if (ctrlWrite) begin
      rxOn_d = pwdata[ERF_RXON_BIT];
    end
  end

  // Inversion lets software wake on anything but a known pattern
  // invert xor equal
  assign csumOk = invertOn ^ csumEqual;

  // Frame class demanded by each mode
  // Reserved codes fall to the default arm, so unique never sees a miss
  always_comb begin
    unique case (mode)
      ERF_PM_OFF: begin
        classOk = 1'h0;
      end
      ERF_PM_CSUM: begin
        classOk = 1'h1;
      end
      ERF_PM_STA0, ERF_PM_STA1: begin
        classOk = daStation;
      end
      ERF_PM_UNI0, ERF_PM_UNI1: begin
        classOk = daUnicast;
      end
      ERF_PM_BC0, ERF_PM_BC1: begin
        classOk = daBroadcast;
      end
      ERF_PM_HASH: begin
        classOk = hashHit;
      end
      ERF_PM_WAKE: begin
        classOk = wakeFrame;
      end
      // Codes ten and up are reserved: never a match
      default: begin
        classOk = 1'h0;
      end
    endcase
  end

  // Checksum condition qualified by the class
  assign modeOk = csumOk && classOk;

  // A disabled filter passes every frame, so the accept logic
  // never rejects on a test that software turned off
  // hash filter gated
  assign hashGate = hashOn ? hashHit : 1'h1;
  assign wakeGate = wakeOn ? wakeFrame : 1'h1;

  // Per-frame results, held until the next frame ends
  // matchValid is a one-cycle pulse; the results themselves stand
  always_comb begin
    valid_d = 1'h0;
    match_d = match_q;
    hash_d = hash_q;
    wake_d = wake_q;
    if (frameDone) begin
      valid_d = 1'h1;
      match_d = modeOk;
      hash_d = hashGate;
      wake_d = wakeGate;
    end
  end

  // Configuration registers
  // Reset leaves every filter off and reception disabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= ERF_RXFC_RST;
      rxOn_q <= 1'h0;
    end else begin
      cfg_q <= cfg_d;
      rxOn_q <= rxOn_d;
    end
  end

  // Bus answer registers
  // pready, prdata and pslverr stand for exactly one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= ERF_ZERO;
      ready_q <= 1'h0;
      err_q <= 1'h0;
    end else begin
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end

  // Per-frame result registers
  // Results clear on reset; a status read then shows no frame seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_q <= 1'h0;
      match_q <= 1'h0;
      hash_q <= 1'h0;
      wake_q <= 1'h0;
    end else begin
      valid_q <= valid_d;
      match_q <= match_d;
      hash_q <= hash_d;
      wake_q <= wake_d;
    end
  end

  // Bus outputs
  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;

  assign receiveOn = rxOn_q;
  assign matchValid = valid_q;
  assign patternMatchOk = match_q;
  assign hashPass = hash_q;
  assign wakePass = wake_q;

  // Lower enables passed on untouched
  assign lowFilterEn = cfg_q[ERF_LOW_W-1:0];

endmodule // erf_filter_cfg

/* verilog/erf_pkg.sv */
package erf_pkg;
  // Register map
  localparam logic [11:0] ERF_RXFC_OFS = 12'h000;
  localparam logic [11:0] ERF_STAT_OFS = 12'h004;
  localparam logic [11:0] ERF_CTRL_OFS = 12'h008;
  // Field positions in receive_filter_config
  localparam int ERF_HASH_BIT = 15;
  localparam int ERF_WAKE_BIT = 14;
  localparam int ERF_INV_BIT = 12;
  localparam int ERF_MODE_LSB = 8;
  localparam int ERF_MODE_W = 4;
  localparam int ERF_LOW_W = 8;
  // Writable bits: 15,14,12,11..0
  localparam logic [31:0] ERF_RXFC_MASK = 32'h0000_dfff;
  localparam logic [31:0] ERF_RXFC_RST = 32'h0000_0000;
  // Control register: receive_on at bit 0
  localparam int ERF_RXON_BIT = 0;
  // Status register bit positions
  localparam int ERF_ST_MATCH = 0;
  localparam int ERF_ST_VALID = 1;
  localparam int ERF_ST_HASH = 2;
  localparam int ERF_ST_WAKE = 3;
  localparam logic [31:0] ERF_ZERO = 32'h0000_0000;
  // Pattern modes
  localparam logic [3:0] ERF_PM_OFF = 4'h0;
  localparam logic [3:0] ERF_PM_CSUM = 4'h1;
  localparam logic [3:0] ERF_PM_STA0 = 4'h2;
  localparam logic [3:0] ERF_PM_STA1 = 4'h3;
  localparam logic [3:0] ERF_PM_UNI0 = 4'h4;
  localparam logic [3:0] ERF_PM_UNI1 = 4'h5;
  localparam logic [3:0] ERF_PM_BC0 = 4'h6;
  localparam logic [3:0] ERF_PM_BC1 = 4'h7;
  localparam logic [3:0] ERF_PM_HASH = 4'h8;
  localparam logic [3:0] ERF_PM_WAKE = 4'h9;
endpackage
